/* logic/cfg_pkg.sv */
// constants, field layout and types of the configuration word decoder
package cfg_pkg;

  // ---------------------------------------------------------------
  // bus and storage widths
  // ---------------------------------------------------------------
  localparam int CFG_W = 12;
  localparam int WB_AW = 14;
  localparam int WB_DW = 32;
  localparam int PIN_W = 8;

  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [11:0] PRIMARY_IDX = 12'hfff;
  localparam logic [11:0] EXTENDED_IDX = 12'hffe;
  localparam logic [11:0] IDENTITY_IDX = 12'hffd;
  localparam logic [WB_AW-1:0] PRIMARY_ADDR = {PRIMARY_IDX, 2'b00};
  localparam logic [WB_AW-1:0] EXTENDED_ADDR = {EXTENDED_IDX, 2'b00};
  localparam logic [WB_AW-1:0] IDENTITY_ADDR = {IDENTITY_IDX, 2'b00};

  // ---------------------------------------------------------------
  // field positions of the primary configuration word
  // ---------------------------------------------------------------
  localparam int CLK_RATIO_BIT = 11;
  localparam int SYNC_BYPASS_BIT = 10;
  localparam int INT_OSC_BIT = 7;
  localparam int RC_DIV_HIGH_BIT = 6;
  localparam int RC_DIV_LOW_BIT = 5;
  localparam int PROTECT_BIT = 3;
  localparam int WDOG_BIT = 2;
  localparam int DRIVE_MID_BIT = 1;
  localparam int DRIVE_LOW_BIT = 0;
  localparam logic [CFG_W-1:0] RESERVED_MASK = 12'h310;

  // ---------------------------------------------------------------
  // values after reset and fixed patterns
  // ---------------------------------------------------------------
  localparam logic [CFG_W-1:0] PRIMARY_RST = 12'hfff;
  localparam logic [CFG_W-1:0] EXTENDED_RST = 12'hfff;
  localparam logic [CFG_W-1:0] SCRAMBLE_KEY = 12'ha5c;
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  localparam logic [1:0] QUARTER_RST = 2'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RC_4MHZ = 2'b00,
    RC_1MHZ = 2'b01,
    RC_128KHZ = 2'b10,
    RC_32KHZ = 2'b11
  } rc_freq_t;

  typedef enum logic [2:0] {
    OSC_LP1 = 3'b000,
    OSC_LP2 = 3'b001,
    OSC_XT1 = 3'b010,
    OSC_XT2 = 3'b011,
    OSC_HS1 = 3'b100,
    OSC_HS2 = 3'b101,
    OSC_HS3 = 3'b110,
    OSC_RC_NET = 3'b111
  } osc_class_t;

  typedef enum logic [1:0] {
    REG_NONE = 2'b00,
    REG_PRIMARY = 2'b01,
    REG_EXTENDED = 2'b10,
    REG_IDENTITY = 2'b11
  } reg_id_t;

endpackage

/* logic/instr_clock_div.sv */
// instruction clock tick generator, full or quarter oscillator rate
`timescale 1ns/100ps
module instr_clock_div (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic quarter_i,
  // tick
  output logic tick_o
);
  import cfg_pkg::*;

  logic [1:0] phase_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= QUARTER_RST;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= !quarter_i || (phase_q == QUARTER_LAST);
    end
  end

endmodule

/* logic/pin_sync.sv */
// input pin conditioning: two-stage synchroniser or bypass
`timescale 1ns/100ps
module pin_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic bypass_i,
  // pins
  input wire logic [cfg_pkg::PIN_W-1:0] pins_i,
  output logic [cfg_pkg::PIN_W-1:0] pins_o
);
  import cfg_pkg::*;

  logic [PIN_W-1:0] stage1_q;
  logic [PIN_W-1:0] stage2_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= pins_i;
      stage2_q <= stage1_q;
    end
  end

  // bypass trades metastability margin for two cycles of latency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_o <= '0;
    end else begin
      pins_o <= bypass_i ? pins_i : stage2_q;
    end
  end

endmodule

/* logic/cfg_decode.sv */
// configuration word store, programming access and static decode
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps

// Behaviour
// - three configuration registers, not altered at run time
// - configuration words reachable only in programming mode
// - identity register fixed; writes leave it unchanged
// - primary word lives at location fff
// - ratio bit: instruction clock osc/1 or osc/4
// - sync bit: two-flop input synchroniser or bypass
// - oscillator bit: internal RC or external oscillator
// - divider bits choose RC frequency
// - shared bit selects crystal feedback resistor
// - protection bit scrambles programmer read data
// - watchdog enable bit drives watchdog enable
// - drive select picks external oscillator class
module cfg_decode #(
  // arbitrary identity value, not tied to any real part
  parameter logic [cfg_pkg::CFG_W-1:0] IDENTITY_VALUE = 12'h5a3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [cfg_pkg::WB_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [cfg_pkg::WB_DW-1:0] dat_i,
  output logic [cfg_pkg::WB_DW-1:0] dat_o,
  output logic ack_o,
  // programming mode pin
  input wire logic prog_mode_i,
  // input pins
  input wire logic [cfg_pkg::PIN_W-1:0] pins_i,
  output logic [cfg_pkg::PIN_W-1:0] pins_o,
  // decoded controls
  output logic instr_tick_o,
  output logic int_osc_en_o,
  output cfg_pkg::rc_freq_t rc_freq_o,
  output logic feedback_res_en_o,
  output cfg_pkg::osc_class_t osc_class_o,
  output logic readout_protected_o,
  output logic watchdog_en_o
);
  import cfg_pkg::*;

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic reg_id_t reg_decode(input logic [WB_AW-1:0] adr);
    reg_id_t id;
    id = REG_NONE;
    case (adr)
      PRIMARY_ADDR: id = REG_PRIMARY;
      EXTENDED_ADDR: id = REG_EXTENDED;
      IDENTITY_ADDR: id = REG_IDENTITY;
      default: id = REG_NONE;
    endcase
    return id;
  endfunction

  function automatic logic [CFG_W-1:0] scramble(input logic [CFG_W-1:0] v);
    return {v[5:0], v[11:6]} ^ SCRAMBLE_KEY;
  endfunction

  function automatic logic [CFG_W-1:0] merge(input logic [CFG_W-1:0] old,
                                             input logic [WB_DW-1:0] wdat,
                                             input logic [3:0] sel);
    logic [CFG_W-1:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      r[11:8] = wdat[11:8];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // programming mode pin synchroniser
  // ---------------------------------------------------------------
  logic prog_meta_q;
  logic prog_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_meta_q <= 1'b0;
      prog_q <= 1'b0;
    end else begin
      prog_meta_q <= prog_mode_i;
      prog_q <= prog_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // bus slave: ack one cycle after the request, write at ack edge
  // ---------------------------------------------------------------
  logic req;
  logic wr_commit;
  reg_id_t req_id;
  logic [CFG_W-1:0] primary_q;
  logic [CFG_W-1:0] extended_q;
  logic [CFG_W-1:0] rd_word;

  assign req = cyc_i && stb_i;
  assign req_id = reg_decode(adr_i);
  // only the programmer may change the words, never the running core
  assign wr_commit = req && we_i && ack_o && prog_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req && !ack_o;
    end
  end

  always_comb begin
    rd_word = '0;
    case (req_id)
      REG_PRIMARY: rd_word = primary_q;
      REG_EXTENDED: rd_word = extended_q;
      REG_IDENTITY: rd_word = IDENTITY_VALUE;
      default: rd_word = '0;
    endcase
  end

  // outside programming mode reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (req && !ack_o && !we_i && prog_q && (req_id != REG_NONE)) begin
      if (primary_q[PROTECT_BIT]) begin
        dat_o <= {{(WB_DW-CFG_W){1'b0}}, rd_word};
      end else begin
        dat_o <= {{(WB_DW-CFG_W){1'b0}}, scramble(rd_word)};
      end
    end else begin
      dat_o <= '0;
    end
  end

  // ---------------------------------------------------------------
  // configuration word storage
  // ---------------------------------------------------------------
  // reserved bits are kept as written, decode below never looks at them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_q <= PRIMARY_RST;
    end else if (wr_commit && (req_id == REG_PRIMARY)) begin
      primary_q <= merge(primary_q, dat_i, sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      extended_q <= EXTENDED_RST;
    end else if (wr_commit && (req_id == REG_EXTENDED)) begin
      extended_q <= merge(extended_q, dat_i, sel_i);
    end
  end
  // identity is a constant; a write to it is acked and dropped

  // ---------------------------------------------------------------
  // decoded controls
  // ---------------------------------------------------------------
  instr_clock_div u_clock_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .quarter_i(primary_q[CLK_RATIO_BIT]),
    .tick_o(instr_tick_o)
  );

  pin_sync u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bypass_i(primary_q[SYNC_BYPASS_BIT]),
    .pins_i(pins_i),
    .pins_o(pins_o)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_osc_en_o <= 1'b0;
      rc_freq_o <= RC_32KHZ;
      feedback_res_en_o <= 1'b0;
      osc_class_o <= OSC_RC_NET;
    end else begin
      int_osc_en_o <= !primary_q[INT_OSC_BIT];
      rc_freq_o <= rc_freq_t'({primary_q[RC_DIV_HIGH_BIT], primary_q[RC_DIV_LOW_BIT]});
      // the resistor only applies to a crystal on the external oscillator
      feedback_res_en_o <= primary_q[INT_OSC_BIT] && primary_q[RC_DIV_HIGH_BIT];
      osc_class_o <= osc_class_t'({primary_q[RC_DIV_LOW_BIT], primary_q[DRIVE_MID_BIT],
                                   primary_q[DRIVE_LOW_BIT]});
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      readout_protected_o <= 1'b0;
      watchdog_en_o <= 1'b0;
    end else begin
      readout_protected_o <= !primary_q[PROTECT_BIT];
      watchdog_en_o <= primary_q[WDOG_BIT];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // reset is lifted on a clock edge, so the checks also skip the edge
  // at which the design still sampled it high
  logic rst_seen_q;

  always_ff @(posedge clk_i) begin
    rst_seen_q <= rst_i;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || rst_seen_q);

  sequence s_prog_write(logic [WB_AW-1:0] a);
    cyc_i && stb_i && we_i && ack_o && prog_q && (adr_i == a) && (sel_i[1:0] == 2'b11);
  endsequence

  sequence s_prog_read(logic [WB_AW-1:0] a);
    cyc_i && stb_i && !we_i && !ack_o && prog_q && (adr_i == a);
  endsequence

  a_run_locked: assert property (
    (!prog_q && !$past(prog_q)) |=> $stable(primary_q) && $stable(extended_q))
    else $error("configuration word changed outside programming mode");

  a_run_read_zero: assert property (
    (cyc_i && stb_i && !we_i && !ack_o && !prog_q) |=> ack_o && (dat_o == '0))
    else $error("read outside programming mode returned data");

  a_identity_read: assert property (
    (s_prog_read(IDENTITY_ADDR) ##0 primary_q[PROTECT_BIT])
    |=> ack_o && (dat_o[CFG_W-1:0] == IDENTITY_VALUE))
    else $error("identity read did not return the fixed value");

  a_primary_write: assert property (
    s_prog_write(PRIMARY_ADDR) |=> primary_q == $past(dat_i[CFG_W-1:0]))
    else $error("programmed primary word not stored");

  a_reserved_kept: assert property (
    s_prog_write(PRIMARY_ADDR) |=> ##1 ((primary_q & RESERVED_MASK) ==
                                       ($past(dat_i[CFG_W-1:0], 2) & RESERVED_MASK)))
    else $error("reserved bits not kept as programmed");

  a_tick_full: assert property (
    (!primary_q[CLK_RATIO_BIT])[*3] |-> instr_tick_o)
    else $error("instruction tick missing at full rate");

  // a ratio change while the four-cycle pattern runs legally breaks it
  a_tick_quarter: assert property (
    @(posedge clk_i) disable iff (rst_i || rst_seen_q || !primary_q[CLK_RATIO_BIT])
    (primary_q[CLK_RATIO_BIT][*4] ##0 instr_tick_o) |=> !instr_tick_o[*3] ##1 instr_tick_o)
    else $error("instruction tick not at quarter rate");

  a_sync_delay: assert property (
    (!primary_q[SYNC_BYPASS_BIT])[*4] |-> pins_o == $past(pins_i, 3))
    else $error("synchronised pins not three cycles late");

  a_sync_bypass: assert property (
    primary_q[SYNC_BYPASS_BIT][*2] |-> pins_o == $past(pins_i))
    else $error("bypassed pins not one cycle late");

  a_osc_choice: assert property (
    ##1 (int_osc_en_o == !$past(primary_q[INT_OSC_BIT])))
    else $error("oscillator choice does not follow its bit");

  a_rc_divider: assert property (
    $past(primary_q[RC_DIV_HIGH_BIT:RC_DIV_LOW_BIT]) == 2'b00 && !$past(rst_i)
    |-> rc_freq_o == RC_4MHZ)
    else $error("divider code 00 did not select 4 MHz");

  a_feedback_int: assert property (
    int_osc_en_o |-> !feedback_res_en_o)
    else $error("feedback resistor enabled with internal oscillator");

  a_scrambled: assert property (
    (s_prog_read(PRIMARY_ADDR) ##0 !primary_q[PROTECT_BIT])
    |=> dat_o[CFG_W-1:0] == scramble($past(primary_q)))
    else $error("protected read returned true contents");

  a_watchdog: assert property (
    $changed(primary_q[WDOG_BIT]) |=> watchdog_en_o == $past(primary_q[WDOG_BIT]))
    else $error("watchdog enable does not follow its bit");

  a_drive_class: assert property (
    (primary_q[INT_OSC_BIT] && primary_q[RC_DIV_LOW_BIT] &&
     (primary_q[DRIVE_MID_BIT:DRIVE_LOW_BIT] == 2'b10))
    |=> osc_class_o == OSC_HS3)
    else $error("drive code 110 did not select the fastest class");

  a_ack_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("acknowledge held longer than one cycle");

  a_ack_answer: assert property (
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not acknowledged in the next cycle");

  a_idle_zero: assert property (
    !ack_o |-> (dat_o == '0))
    else $error("read data not zero outside the acknowledge cycle");

  a_unmapped_zero: assert property (
    (cyc_i && stb_i && !we_i && !ack_o && (req_id == REG_NONE)) |=> (dat_o == '0))
    else $error("unmapped read returned data");

  a_ext_write: assert property (
    s_prog_write(EXTENDED_ADDR) |=> extended_q == $past(dat_i[CFG_W-1:0]))
    else $error("programmed extended word not stored");

  a_ext_read: assert property (
    (s_prog_read(EXTENDED_ADDR) ##0 primary_q[PROTECT_BIT])
    |=> dat_o[CFG_W-1:0] == $past(extended_q))
    else $error("extended word read back wrong");

  a_primary_read: assert property (
    (s_prog_read(PRIMARY_ADDR) ##0 primary_q[PROTECT_BIT])
    |=> dat_o[CFG_W-1:0] == $past(primary_q))
    else $error("unprotected primary read returned wrong data");

  a_upper_zero: assert property (
    dat_o[WB_DW-1:CFG_W] == '0)
    else $error("read data above the word width not zero");

  a_ident_wr_drop: assert property (
    (cyc_i && stb_i && we_i && ack_o && (adr_i == IDENTITY_ADDR))
    |=> $stable(primary_q) && $stable(extended_q))
    else $error("identity write disturbed a configuration word");

  a_protect_flag: assert property (
    ##1 (readout_protected_o == !$past(primary_q[PROTECT_BIT])))
    else $error("protection flag does not follow its bit");

  a_feedback_ext: assert property (
    (primary_q[INT_OSC_BIT] && primary_q[RC_DIV_HIGH_BIT]) |=> feedback_res_en_o)
    else $error("feedback resistor not enabled for the crystal");

endmodule

/* testbench/cfg_programmer.sv */
// device programmer model: wishbone master and programming mode pin
`timescale 1ns/100ps
module cfg_programmer (
  // clock
  input wire logic clk_i,
  // wishbone master
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [cfg_pkg::WB_AW-1:0] adr_o,
  output logic [3:0] sel_o,
  output logic [cfg_pkg::WB_DW-1:0] dat_o,
  input wire logic [cfg_pkg::WB_DW-1:0] dat_i,
  input wire logic ack_i,
  // programming mode pin
  output logic prog_mode_o
);
  import cfg_pkg::*;

  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = '0;
    sel_o = 4'h0;
    dat_o = '0;
    prog_mode_o = 1'b0;
  end

  // mode held three edges so the device's synchroniser has settled
  task automatic set_prog(input logic v);
    @(posedge clk_i);
    prog_mode_o <= v;
    repeat (3) @(posedge clk_i);
  endtask

  // released address and data lines show the inverse so stale values are never mistaken for live ones
  task automatic xfer(input int gap, input logic w, input logic [WB_AW-1:0] a,
                      input logic [WB_DW-1:0] d, output logic [WB_DW-1:0] r);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    r = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule

/* testbench/tb_primary_configuration_word_configuration_decode.sv */
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
module tb_primary_configuration_word_configuration_decode;
  import cfg_pkg::*;
  // arbitrary identity value
  localparam logic [CFG_W-1:0] ID_VAL = 12'h5a3;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i, stb_i, we_i, ack_o, prog_mode_i, instr_tick_o;
  logic [WB_AW-1:0] adr_i;
  logic [3:0] sel_i;
  logic [WB_DW-1:0] dat_i, dat_o;
  logic [PIN_W-1:0] pins_i = '0;
  logic [PIN_W-1:0] pins_o;
  logic int_osc_en_o, feedback_res_en_o, readout_protected_o, watchdog_en_o;
  rc_freq_t rc_freq_o;
  osc_class_t osc_class_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  integer seed = 32'h5bee6844;
  logic [31:0] exp_q[$];
  logic [23:0] ph = '0;

  always #4 clk_i = ~clk_i;

  cfg_decode #(.IDENTITY_VALUE(ID_VAL)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .prog_mode_i(prog_mode_i), .pins_i(pins_i), .pins_o(pins_o),
    .instr_tick_o(instr_tick_o), .int_osc_en_o(int_osc_en_o), .rc_freq_o(rc_freq_o),
    .feedback_res_en_o(feedback_res_en_o), .osc_class_o(osc_class_o),
    .readout_protected_o(readout_protected_o), .watchdog_en_o(watchdog_en_o));

  cfg_programmer u_prog (.clk_i(clk_i), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
    .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i), .dat_i(dat_o), .ack_i(ack_o),
    .prog_mode_o(prog_mode_i));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function logic [11:0] scr(input logic [11:0] v);
    return {v[5:0], v[11:6]} ^ SCRAMBLE_KEY;
  endfunction

  // random pins every edge; ph keeps what the last three edges sampled
  always @(posedge clk_i) begin
    pins_i <= PIN_W'($random(seed));
    ph <= {ph[15:0], pins_i};
  end

  // read data is judged against the oldest note in the queue
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      chk(dat_o, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
  end

  task rd(input logic [WB_AW-1:0] a, input logic [31:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    u_prog.xfer($random(seed) & 3, 1'b0, a, 32'h0, r);
  endtask

  task wr(input logic [WB_AW-1:0] a, input logic [11:0] v);
    logic [31:0] r;
    u_prog.xfer(0, 1'b1, a, {20'h0, v}, r);
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task chk_dec(input logic [11:0] w);
    chk(32'(int_osc_en_o), 32'(!w[INT_OSC_BIT]));
    chk(32'(rc_freq_o), 32'(w[6:5]));
    chk(32'(feedback_res_en_o), 32'(w[7] & w[6]));
    chk(32'(osc_class_o), 32'({w[5], w[1:0]}));
    chk(32'(readout_protected_o), 32'(!w[3]));
    chk(32'(watchdog_en_o), 32'(w[2]));
  endtask

  task tick_cnt(input logic [11:0] w, input int e);
    int n;
    n = 0;
    wr(PRIMARY_ADDR, w);
    repeat (8) begin
      @(posedge clk_i);
      #1;
      n += int'(instr_tick_o);
    end
    chk(n, e);
  endtask

  task pin_run(input logic [11:0] w);
    wr(PRIMARY_ADDR, w);
    repeat (4) @(posedge clk_i);
    repeat (8) begin
      @(posedge clk_i);
      #1;
      chk(32'(pins_o), 32'(w[10] ? ph[7:0] : ph[23:16]));
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    logic [11:0] w;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk_dec(PRIMARY_RST);
    $display("test reset_decode done");
    wr(PRIMARY_ADDR, 12'h000);
    chk_dec(PRIMARY_RST);
    rd(PRIMARY_ADDR, 32'h0);
    u_prog.set_prog(1'b1);
    rd(PRIMARY_ADDR, {20'h0, PRIMARY_RST});
    rd(14'h0100, 32'h0);
    $display("test access done");
    for (int i = 0; i < 32; i++) begin
      w = 12'($random(seed));
      w[1:0] = i[1:0];
      w[6:5] = i[3:2];
      w[7] = i[4];
      wr(PRIMARY_ADDR, w);
      chk_dec(w);
      rd(PRIMARY_ADDR, {20'h0, w[3] ? w : scr(w)});
    end
    $display("test decode_sweep done");
    wr(PRIMARY_ADDR, 12'hfff);
    wr(IDENTITY_ADDR, ~ID_VAL);
    rd(IDENTITY_ADDR, {20'h0, ID_VAL});
    wr(EXTENDED_ADDR, 12'h3c6);
    rd(EXTENDED_ADDR, 32'h3c6);
    wr(PRIMARY_ADDR, 12'hff7);
    rd(IDENTITY_ADDR, {20'h0, scr(ID_VAL)});
    $display("test identity done");
    tick_cnt(12'h7ff, 8);
    tick_cnt(12'hfff, 2);
    pin_run(12'hbff);
    pin_run(12'hfff);
    $display("test clock_pins done");
    u_prog.set_prog(1'b0);
    wr(PRIMARY_ADDR, 12'h000);
    chk_dec(12'hfff);
    $display("test runtime_lock done");
    end_sim;
  end

  // the tests need about 500 cycles; this allows many times that
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
endmodule
